// *** core/dcr_regs.sv ***
// regulator configuration bank with an AXI4-Lite slave port
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module dcr_regs
   import dcr_pkg::*;
#(
   parameter int SWITCH_SLOTS = 16
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // extra reset causes, synchronous one-cycle requests
   input  wire logic        por_reset_req,
   input  wire logic        pin_reset_req,
   input  wire logic        bod_reset_req,
   // sleep state of the chip
   input  wire logic        mid_sleep_active,
   input  wire logic        hibernate_active,
   // axi4-lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // controls to the analog regulator
   output dcr_mode_t        active_mode,
   output logic [1:0]       economy_comparator_bias,
   output logic [2:0]       quiet_current_limit_level,
   output logic [2:0]       economy_current_limit_level,
   output logic [3:0]       bypass_current_limit_level,
   output logic             bypass_limit_active,
   output logic [SWITCH_SLOTS-1:0] low_side_switch_en,
   output logic [SWITCH_SLOTS-1:0] high_side_switch_en,
   output logic             continuous_conduction,
   output logic             zero_crossing_detect,
   output logic             reverse_limit_active,
   output logic [2:0]       reverse_current_threshold,
   output logic [1:0]       zero_detect_blanking_delay,
   output logic [1:0]       limiter_blanking_delay
);

   // ------------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------------
   // the switch count fields are four bits wide, so exactly sixteen slots
   if (SWITCH_SLOTS != 16) begin : g_bad_slots
      $error("dcr_regs: SWITCH_SLOTS must be 16");
   end

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [31:0]     mode_ctrl_ff;
   logic [31:0]     misc_ff;
   logic [31:0]     zdet_ff;
   logic [31:0]     clim_ff;
   logic            aw_held_ff;
   logic [11:0]     awaddr_ff;
   logic            w_held_ff;
   logic [31:0]     wdata_ff;
   logic [3:0]      wstrb_ff;
   logic            bvalid_ff;
   logic [1:0]      bresp_ff;
   logic            rvalid_ff;
   logic [31:0]     rdata_ff;
   logic [1:0]      rresp_ff;
   logic            field_rst;
   logic            do_write;
   logic [31:0]     lane_mask;
   logic            wr_hit;
   logic [31:0]     rd_word;
   logic            rd_hit;
   dcr_mode_ctrl_t  mode_ctrl;
   dcr_misc_t       misc;
   dcr_zdet_t       zdet;
   dcr_clim_t       clim;
   dcr_mode_t       nxt_active_mode;
   dcr_mode_t       active_mode_ff;
   logic            ccm_ff;
   logic            zcd_ff;
   logic            rlim_ff;
   logic            byp_ff;
   logic [SWITCH_SLOTS-1:0] low_en_ff;
   logic [SWITCH_SLOTS-1:0] high_en_ff;

   assign mode_ctrl = dcr_mode_ctrl_t'(mode_ctrl_ff);
   assign misc      = dcr_misc_t'(misc_ff);
   assign zdet      = dcr_zdet_t'(zdet_ff);
   assign clim      = dcr_clim_t'(clim_ff);

   // every reset cause puts the fields back to their reset values
   assign field_rst = !aresetn || por_reset_req || pin_reset_req || bod_reset_req;

   // ------------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------------
   // address and data are taken independently and held until both exist
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         awaddr_ff  <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   // byte strobes widen to a bit mask
   assign lane_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

   // decode of the held write address; the low two bits are ignored
   always_comb begin
      unique case ({awaddr_ff[11:2], 2'b00})
         ADDR_MODE_CTRL, ADDR_MODE_STATUS, ADDR_MISC, ADDR_ZDET, ADDR_CLIM: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // response: okay for mapped words, decode error otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   // ------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------
   // reserved bits never store, so they always read back as zero
   always_ff @(posedge aclk) begin
      if (field_rst) begin
         mode_ctrl_ff <= RST_MODE_CTRL;
      end else if (do_write && {awaddr_ff[11:2], 2'b00} == ADDR_MODE_CTRL) begin
         mode_ctrl_ff <= ((mode_ctrl_ff & ~lane_mask) | (wdata_ff & lane_mask)) & MSK_MODE_CTRL;
      end
   end

   always_ff @(posedge aclk) begin
      if (field_rst) begin
         misc_ff <= RST_MISC;
      end else if (do_write && {awaddr_ff[11:2], 2'b00} == ADDR_MISC) begin
         misc_ff <= ((misc_ff & ~lane_mask) | (wdata_ff & lane_mask)) & MSK_MISC;
      end
   end

   always_ff @(posedge aclk) begin
      if (field_rst) begin
         zdet_ff <= RST_ZDET;
      end else if (do_write && {awaddr_ff[11:2], 2'b00} == ADDR_ZDET) begin
         zdet_ff <= ((zdet_ff & ~lane_mask) | (wdata_ff & lane_mask)) & MSK_ZDET;
      end
   end

   always_ff @(posedge aclk) begin
      if (field_rst) begin
         clim_ff <= RST_CLIM;
      end else if (do_write && {awaddr_ff[11:2], 2'b00} == ADDR_CLIM) begin
         clim_ff <= ((clim_ff & ~lane_mask) | (wdata_ff & lane_mask)) & MSK_CLIM;
      end
   end

   // ------------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------------
   assign s_axi_arready = !rvalid_ff;

   // status word shows the mode the regulator is really running in
   always_comb begin
      rd_hit  = 1'b1;
      unique case ({s_axi_araddr[11:2], 2'b00})
         ADDR_MODE_CTRL:   rd_word = mode_ctrl_ff;
         ADDR_MODE_STATUS: rd_word = {30'h0000_0000, active_mode_ff};
         ADDR_MISC:        rd_word = misc_ff;
         ADDR_ZDET:        rd_word = zdet_ff;
         ADDR_CLIM:        rd_word = clim_ff;
         default: begin
            rd_word = 32'h0000_0000;
            rd_hit  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_word;
         rresp_ff  <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;

   // ------------------------------------------------------------------
   // operating mode selection
   // ------------------------------------------------------------------
   // a set override bit forces economy in its sleep state, the mid sleep bit only outside hibernate; the off case
   // relies on software clearing the overrides
   always_comb begin
      nxt_active_mode = mode_ctrl.regulator_mode_sel;
      if (hibernate_active && mode_ctrl.hibernate_mode_keep) begin
         nxt_active_mode = DCR_MODE_ECON;
      end else if (!hibernate_active && mid_sleep_active && mode_ctrl.mid_sleep_mode_override) begin
         nxt_active_mode = DCR_MODE_ECON;
      end
   end

   always_ff @(posedge aclk) begin
      if (field_rst) begin
         active_mode_ff <= DCR_MODE_BYPASS;
      end else begin
         active_mode_ff <= nxt_active_mode;
      end
   end

   // ------------------------------------------------------------------
   // zero detector and current limit controls
   // ------------------------------------------------------------------
   // economy mode overrides the force bit: the detector only watches crossings
   always_ff @(posedge aclk) begin
      if (field_rst) begin
         ccm_ff  <= 1'b0;
         zcd_ff  <= 1'b0;
         rlim_ff <= 1'b0;
         byp_ff  <= 1'b0;
      end else begin
         ccm_ff  <= nxt_active_mode == DCR_MODE_QUIET && misc.force_continuous_conduction;
         zcd_ff  <= nxt_active_mode == DCR_MODE_ECON || (nxt_active_mode == DCR_MODE_QUIET
                    && misc.force_continuous_conduction);
         rlim_ff <= nxt_active_mode == DCR_MODE_QUIET && !misc.force_continuous_conduction;
         byp_ff  <= nxt_active_mode == DCR_MODE_BYPASS && clim.bypass_limit_enable;
      end
   end

   // ------------------------------------------------------------------
   // power switch enables
   // ------------------------------------------------------------------
   // thermometer code: slot i is on when the count field is at least i
   for (genvar i = 0; i < SWITCH_SLOTS; i++) begin : g_switch
      always_ff @(posedge aclk) begin
         if (field_rst) begin
            low_en_ff[i]  <= 1'b0;
            high_en_ff[i] <= 1'b0;
         end else begin
            low_en_ff[i]  <= 32'(i) <= 32'(misc.low_side_switch_count);
            high_en_ff[i] <= 32'(i) <= 32'(misc.high_side_switch_count);
         end
      end
   end

   // ------------------------------------------------------------------
   // outputs to the regulator
   // ------------------------------------------------------------------
   assign active_mode                 = active_mode_ff;
   assign economy_comparator_bias     = misc.economy_comparator_bias;
   assign quiet_current_limit_level   = misc.quiet_current_limit_level;
   assign economy_current_limit_level = misc.economy_current_limit_level;
   assign bypass_current_limit_level  = misc.bypass_current_limit_level;
   assign bypass_limit_active         = byp_ff;
   assign low_side_switch_en          = low_en_ff;
   assign high_side_switch_en         = high_en_ff;
   assign continuous_conduction       = ccm_ff;
   assign zero_crossing_detect        = zcd_ff;
   assign reverse_limit_active        = rlim_ff;
   assign reverse_current_threshold   = zdet.reverse_current_threshold;
   assign zero_detect_blanking_delay  = zdet.zero_detect_blanking_delay;
   assign limiter_blanking_delay      = clim.limiter_blanking_delay;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   a_mode_reset_bypass: assert property (@(posedge aclk)
      $past(field_rst) |-> mode_ctrl.regulator_mode_sel == DCR_MODE_BYPASS
         && active_mode_ff == DCR_MODE_BYPASS)
      else $error("mode not bypass after reset");

   a_hibernate_econ: assert property (@(posedge aclk) disable iff (field_rst)
      hibernate_active && mode_ctrl.hibernate_mode_keep |=> active_mode_ff == DCR_MODE_ECON)
      else $error("hibernate override not economy");

   a_mid_sleep_follow: assert property (@(posedge aclk) disable iff (field_rst)
      mid_sleep_active && !hibernate_active && !mode_ctrl.mid_sleep_mode_override
         ##1 !field_rst |-> active_mode_ff == $past(mode_ctrl.regulator_mode_sel))
      else $error("mid sleep mode does not follow mode field");

   a_fields_reset: assert property (@(posedge aclk)
      (por_reset_req || bod_reset_req || pin_reset_req) |=> misc_ff == RST_MISC
         && zdet_ff == RST_ZDET && clim_ff == RST_CLIM && mode_ctrl_ff == RST_MODE_CTRL)
      else $error("fields not restored by reset cause");

   a_bias_field: assert property (@(posedge aclk) disable iff (field_rst)
      do_write && awaddr_ff == ADDR_MISC && wstrb_ff[3]
         |=> economy_comparator_bias == $past(wdata_ff[29:28]))
      else $error("comparator bias not written");

   a_bypass_gate: assert property (@(posedge aclk) disable iff (field_rst)
      !clim.bypass_limit_enable |=> !bypass_limit_active)
      else $error("bypass limit active without enable");

   a_switch_count: assert property (@(posedge aclk) disable iff (field_rst)
      ##1 !field_rst |-> $countones(low_side_switch_en)
         == 32'($past(misc.low_side_switch_count)) + 1)
      else $error("low side switch count wrong");

   a_high_count: assert property (@(posedge aclk) disable iff (field_rst)
      ##1 !field_rst |-> high_side_switch_en[$past(misc.high_side_switch_count)]
         && (high_side_switch_en >> $past(misc.high_side_switch_count)) == 16'h0001)
      else $error("high side switch count wrong");

   a_econ_zero_cross: assert property (@(posedge aclk) disable iff (field_rst)
      active_mode_ff == DCR_MODE_ECON |-> zero_crossing_detect && !continuous_conduction
         && !reverse_limit_active)
      else $error("economy mode not zero crossing");

   a_quiet_force: assert property (@(posedge aclk) disable iff (field_rst)
      active_mode_ff == DCR_MODE_QUIET && $past(misc.force_continuous_conduction)
         |-> continuous_conduction && !reverse_limit_active)
      else $error("forced conduction not applied");

   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid ##1 s_axi_bvalid == !$past(s_axi_bready))
      else $error("write answer not raised");

endmodule

`default_nettype wire

// *** core/dcr_pkg.sv ***
// constants, field layouts and carriers for the regulator configuration bank
package dcr_pkg;

   // ------------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------------
   localparam logic [11:0] ADDR_MODE_CTRL   = 12'h044;
   localparam logic [11:0] ADDR_MODE_STATUS = 12'h048;
   localparam logic [11:0] ADDR_MISC        = 12'h04c;
   localparam logic [11:0] ADDR_ZDET        = 12'h050;
   localparam logic [11:0] ADDR_CLIM        = 12'h054;

   // ------------------------------------------------------------------
   // reset values and writable-bit masks
   // ------------------------------------------------------------------
   localparam logic [31:0] RST_MODE_CTRL = 32'h0000_0030;
   localparam logic [31:0] RST_MISC      = 32'h3330_7700;
   localparam logic [31:0] RST_ZDET      = 32'h0000_0130;
   localparam logic [31:0] RST_CLIM      = 32'h0000_0100;
   localparam logic [31:0] MSK_MODE_CTRL = 32'h0000_0033;
   localparam logic [31:0] MSK_MISC      = 32'h377f_ff01;
   localparam logic [31:0] MSK_ZDET      = 32'h0000_0370;
   localparam logic [31:0] MSK_CLIM      = 32'h0000_2300;

   // ------------------------------------------------------------------
   // bus answers
   // ------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // regulator operating modes as held in the mode field
   typedef enum logic [1:0] {
      DCR_MODE_BYPASS = 2'h0,
      DCR_MODE_QUIET  = 2'h1,
      DCR_MODE_ECON   = 2'h2,
      DCR_MODE_OFF    = 2'h3
   } dcr_mode_t;

   typedef struct packed {
      logic [25:0] rsv_hi;
      logic        hibernate_mode_keep;
      logic        mid_sleep_mode_override;
      logic [1:0]  rsv_lo;
      dcr_mode_t   regulator_mode_sel;
   } dcr_mode_ctrl_t;

   typedef struct packed {
      logic [1:0] rsv31;
      logic [1:0] economy_comparator_bias;
      logic       rsv27;
      logic [2:0] quiet_current_limit_level;
      logic       rsv23;
      logic [2:0] economy_current_limit_level;
      logic [3:0] bypass_current_limit_level;
      logic [3:0] low_side_switch_count;
      logic [3:0] high_side_switch_count;
      logic [6:0] rsv7;
      logic       force_continuous_conduction;
   } dcr_misc_t;

   typedef struct packed {
      logic [21:0] rsv31;
      logic [1:0]  zero_detect_blanking_delay;
      logic        rsv7;
      logic [2:0]  reverse_current_threshold;
      logic [3:0]  rsv3;
   } dcr_zdet_t;

   typedef struct packed {
      logic [17:0] rsv31;
      logic        bypass_limit_enable;
      logic [2:0]  rsv12;
      logic [1:0]  limiter_blanking_delay;
      logic [7:0]  rsv7;
   } dcr_clim_t;

endpackage

// *** sim/tb.sv ***
// self-checking bench for the regulator configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dcr_pkg::*;
   // ------------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------------
   logic        aclk, aresetn, por_q, pin_q, bod_q, mid_q, hib_q;
   logic        awv, wv, arv, awr, wrdy, bv, arr, rv, bla, cc, zc, rla;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0]  br, rr, ecb, zbd, lbd;
   logic [2:0]  qcl, ecl, rct;
   logic [3:0]  bcl;
   logic [15:0] lse, hse, seed;
   dcr_mode_t   am;
   int          err_total, num_checks;

   // bready, rready held high: the bench always accepts answers at once
   dcr_regs dut (
      .aclk(aclk), .aresetn(aresetn), .por_reset_req(por_q), .pin_reset_req(pin_q),
      .bod_reset_req(bod_q), .mid_sleep_active(mid_q), .hibernate_active(hib_q),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .active_mode(am), .economy_comparator_bias(ecb), .quiet_current_limit_level(qcl),
      .economy_current_limit_level(ecl), .bypass_current_limit_level(bcl),
      .bypass_limit_active(bla), .low_side_switch_en(lse), .high_side_switch_en(hse),
      .continuous_conduction(cc), .zero_crossing_detect(zc), .reverse_limit_active(rla),
      .reverse_current_threshold(rct), .zero_detect_blanking_delay(zbd),
      .limiter_blanking_delay(lbd));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] rnd();
      logic [15:0] t;
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      t = seed;
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return {t, seed};
   endfunction

   // hibernate wins over mid sleep; a set override bit means economy
   function automatic dcr_mode_t exp_mode(input logic [5:0] c, input logic mid, input logic hib);
      if (hib) return c[5] ? DCR_MODE_ECON : dcr_mode_t'(c[1:0]);
      if (mid) return c[4] ? DCR_MODE_ECON : dcr_mode_t'(c[1:0]);
      return dcr_mode_t'(c[1:0]);
   endfunction

   function automatic logic [15:0] therm(input logic [3:0] c);
      logic [16:0] t;
      t = (17'h1 << ({1'b0, c} + 5'h1)) - 17'h1;
      return t[15:0];
   endfunction

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // bounded wait step: a hang counts as a mismatch and ends the run
   task automatic tick(input int i);
      if (i > 40) begin
         err_total++;
         report_and_stop();
      end else begin
         @(negedge aclk);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw;
      int   i;
      i = 0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
         tick(i++);
         ta = awv && awr;
         tw = wv && wrdy;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (awv || wv);
      i = 0;
      do tick(i++); while (!bv);
      r = br;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      i = 0;
      ara <= a;
      arv <= 1'b1;
      do tick(i++); while (!arr);
      @(posedge aclk);
      arv <= 1'b0;
      i = 0;
      do tick(i++); while (!rv);
      d = rdat;
      r = rr;
      @(posedge aclk);
   endtask

   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(nm, exp, d);
      chk("rresp", RESP_OKAY, r);
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [31:0] d, r32;
      logic [5:0]  c;
      logic [1:0]  rs;
      dcr_mode_t   m;
      {aresetn, por_q, pin_q, bod_q, mid_q, hib_q, awv, wv, arv} = '0;
      awa = '0;
      ara = '0;
      wd = '0;
      seed = 16'd26442;
      err_total = 0;
      num_checks = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk("ctrl", ADDR_MODE_CTRL, 32'h0000_0030); // rst
      rchk("misc", ADDR_MISC, 32'h3330_7700); // rst
      rchk("zdet", ADDR_ZDET, 32'h0000_0130); // rst
      rchk("clim", ADDR_CLIM, 32'h0000_0100); // rst
      chk("lsw", 16'h00ff, lse); // seven plus one
      chk("hsw", 16'h00ff, hse); // seven plus one
      rd(12'h0f0, d, rs);
      chk("unmapped rresp", RESP_DECERR, rs);
      wr(12'h0f0, 32'hffff_ffff, rs);
      chk("unmapped bresp", RESP_DECERR, rs);
      $display("test reset values done");
      // every mode crossed with random sleep states and field values
      for (int k = 0; k < 16; k++) begin
         // reserved bits zero; quiet limit level kept at 3 or below for any switch count
         d = rnd() & MSK_MISC & 32'hfbff_ffff;
         r32 = rnd();
         // overrides cleared whenever the mode field is off
         c = {(k[1:0] == 2'h3) ? 2'b00 : r32[5:4], 2'b00, k[1:0]};
         mid_q <= r32[8];
         hib_q <= r32[9];
         wr(ADDR_MISC, d, rs); // switch counts set before the mode
         wr(ADDR_MODE_CTRL, {26'h0, c}, rs);
         wr(ADDR_CLIM, (r32 & 32'h0000_2000) | 32'h0000_0100, rs);
         chk("bresp", RESP_OKAY, rs);
         rchk("misc rw", ADDR_MISC, d & MSK_MISC); // fields
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         m = exp_mode(c, r32[8], r32[9]);
         chk("mode", m, am);
         chk("ccm", (m == DCR_MODE_QUIET) && d[0], cc);
         chk("zcd", m == DCR_MODE_ECON || (m == DCR_MODE_QUIET && d[0]), zc);
         chk("rlim", (m == DCR_MODE_QUIET) && !d[0], rla);
         chk("byp", (m == DCR_MODE_BYPASS) && r32[13], bla);
         chk("lsw", therm(d[15:12]), lse);
         chk("hsw", therm(d[11:8]), hse);
         chk("bias", d[29:28], ecb);
         chk("qlim", d[26:24], qcl);
         chk("elim", d[22:20], ecl);
         chk("blim", d[19:16], bcl);
         @(posedge aclk);
      end
      $display("test modes and fields done");
      // each reset cause alone restores the bank
      for (int j = 0; j < 3; j++) begin
         d = (rnd() & 32'h0000_0070) | 32'h0000_0100; // blanking delay left at one
         wr(ADDR_ZDET, d, rs);
         rchk("zdet rw", ADDR_ZDET, d); // threshold field
         chk("rct", d[6:4], rct);
         {por_q, pin_q, bod_q} <= 3'b100 >> j;
         @(posedge aclk);
         {por_q, pin_q, bod_q} <= 3'b000;
         @(posedge aclk);
         rchk("misc", ADDR_MISC, 32'h3330_7700);
         rchk("zdet", ADDR_ZDET, 32'h0000_0130);
         rchk("ctrl", ADDR_MODE_CTRL, 32'h0000_0030);
         chk("rct rst", 3'h3, rct);
         chk("zbd", 2'h1, zbd);
         chk("lbd", 2'h1, lbd);
      end
      $display("test reset causes done");
      report_and_stop();
   end
endmodule
`default_nettype wire
